/* core/fanout_output_enable_control.sv */
// Summary of operation
// - Pin low runs output, high drives low
// - Twenty outputs, each enabled independently
// - Enable pins map to outputs five..twelve
// - Output active when bit one, pin zero
// - Register enable bits active high, reset enabled
// - Enable pins asynchronous, synchronised before use
// - Strap high turns shared pins into side-band
// - Load strobe fall copies shift register
// - Side-band mode ignores pins and bits
// - Bus address chosen by two straps
// - Power-down drives every output low
// - Shift one bit per rising shift clock
// - Enable resumes glitch-free within ten periods
// - Disable gives four clocks, then stops; power-down skips the four
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "fanout_oe_cfg.svh"

module fanout_output_enable_control (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic reference_input,
	input wire logic [`OE_PIN_COUNT-1:0] output_enable_n,
	input wire logic sideband_select_strap,
	input wire logic power_good_powerdown,
	input wire fanout_oe_pkg::tri_level_e address_strap_low,
	input wire fanout_oe_pkg::tri_level_e address_strap_high,
	// Differential outputs
	output logic [`OE_NUM_OUTPUTS-1:0] differential_output_p,
	output logic [`OE_NUM_OUTPUTS-1:0] differential_output_n
);
	import fanout_oe_pkg::*;

	localparam int N = `OE_NUM_OUTPUTS;
	localparam int P = `OE_PIN_COUNT;

	// Synchronisers: two stages; a third on reference, pins and power-good finds edges
	logic ref_s1_r, ref_s2_r, ref_s3_r;
	logic [P-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic sel_s1_r, sel_s2_r;
	logic pg_s1_r, pg_s2_r, pg_s3_r;
	logic [1:0] slo_s1_r, slo_s2_r, shi_s1_r, shi_s2_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_s1_r <= 1'b0;
			ref_s2_r <= 1'b0;
			ref_s3_r <= 1'b0;
		end else begin
			ref_s1_r <= reference_input;
			ref_s2_r <= ref_s1_r;
			ref_s3_r <= ref_s2_r;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
		end else begin
			pin_s1_r <= output_enable_n;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
		end else begin
			sel_s1_r <= sideband_select_strap;
			sel_s2_r <= sel_s1_r;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pg_s1_r <= 1'b0;
			pg_s2_r <= 1'b0;
			pg_s3_r <= 1'b0;
		end else begin
			pg_s1_r <= power_good_powerdown;
			pg_s2_r <= pg_s1_r;
			pg_s3_r <= pg_s2_r;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			slo_s1_r <= 2'h0;
			slo_s2_r <= 2'h0;
			shi_s1_r <= 2'h0;
			shi_s2_r <= 2'h0;
		end else begin
			slo_s1_r <= address_strap_low;
			slo_s2_r <= slo_s1_r;
			shi_s1_r <= address_strap_high;
			shi_s2_r <= shi_s1_r;
		end
	end

	logic ref_rise, ref_low, power_down, sideband_select;
	assign ref_rise = ref_s2_r & ~ref_s3_r;
	assign ref_low = ~ref_s2_r;
	assign power_down = ~pg_s2_r;
	assign sideband_select = sel_s2_r;

	// Strap capture at first power-good rise
	function automatic logic [7:0] bus_address(logic [1:0] hi,
		logic [1:0] lo);
		logic [7:0] a;
		a = `OE_SMB_ADDR_LL;
		case ({hi, lo})
			{TRI_LOW, TRI_LOW}: a = `OE_SMB_ADDR_LL;
			{TRI_LOW, TRI_MID}: a = `OE_SMB_ADDR_LM;
			{TRI_LOW, TRI_HIGH}: a = `OE_SMB_ADDR_LH;
			{TRI_MID, TRI_LOW}: a = `OE_SMB_ADDR_ML;
			{TRI_MID, TRI_MID}: a = `OE_SMB_ADDR_MM;
			{TRI_MID, TRI_HIGH}: a = `OE_SMB_ADDR_MH;
			{TRI_HIGH, TRI_LOW}: a = `OE_SMB_ADDR_HL;
			{TRI_HIGH, TRI_MID}: a = `OE_SMB_ADDR_HM;
			{TRI_HIGH, TRI_HIGH}: a = `OE_SMB_ADDR_HH;
			default: a = `OE_SMB_ADDR_LL;
		endcase
		return a;
	endfunction

	logic straps_taken_r, strap_take;
	logic [1:0] strap_lo_r, strap_hi_r;
	logic [7:0] bus_addr_r;
	assign strap_take = !straps_taken_r && pg_s2_r && !pg_s3_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			straps_taken_r <= 1'b0;
		end else if (strap_take) begin
			straps_taken_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_lo_r <= 2'h0;
			strap_hi_r <= 2'h0;
			bus_addr_r <= `OE_SMB_ADDR_LL;
		end else if (strap_take) begin
			strap_lo_r <= slo_s2_r;
			strap_hi_r <= shi_s2_r;
			bus_addr_r <= bus_address(shi_s2_r, slo_s2_r);
		end
	end

	// Side-band shift and output registers
	logic [N-1:0] shift_r, sb_out_r;
	logic sb_clk_rise, sb_strobe_fall, sb_strobe_high;
	assign sb_clk_rise = pin_s2_r[`OE_PIN_SHIFT]
		& ~pin_s3_r[`OE_PIN_SHIFT];
	assign sb_strobe_high = pin_s2_r[`OE_PIN_STROBE];
	assign sb_strobe_fall = ~pin_s2_r[`OE_PIN_STROBE]
		& pin_s3_r[`OE_PIN_STROBE];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shift_r <= `OE_SHIFT_RESET;
		end else if (sideband_select && sb_strobe_high
			&& sb_clk_rise) begin
			// First bit shifted ends in bit 0
			shift_r <= {pin_s2_r[`OE_PIN_DATA], shift_r[N-1:1]};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sb_out_r <= `OE_SB_RESET;
		end else if (sideband_select && sb_strobe_fall) begin
			sb_out_r <= shift_r;
		end
	end

	// APB slave, zero wait states
	logic [N-1:0] enable_r, mask_r, active;
	logic setup, access;
	assign setup = psel & ~penable;
	assign access = psel & penable & pready;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Error flag stands with ready only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else if (!setup) begin
			pslverr <= 1'b0;
		end else begin
			case (paddr)
				`OE_ADDR_ENABLE, `OE_ADDR_MASK, `OE_ADDR_STATUS,
				`OE_ADDR_ACTIVE, `OE_ADDR_SB_OUT: pslverr <= 1'b0;
				default: pslverr <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				`OE_ADDR_ENABLE: prdata <= {12'h000, enable_r};
				`OE_ADDR_MASK: prdata <= {12'h000, mask_r};
				`OE_ADDR_STATUS: begin
					prdata[`OE_ST_SELECT] <= sideband_select;
					prdata[`OE_ST_POWER_GOOD] <= pg_s2_r;
					prdata[`OE_ST_STRAP_LO+:2] <= strap_lo_r;
					prdata[`OE_ST_STRAP_HI+:2] <= strap_hi_r;
					prdata[`OE_ST_BUS_ADDR+:8] <= bus_addr_r;
				end
				`OE_ADDR_ACTIVE: prdata <= {12'h000, active};
				`OE_ADDR_SB_OUT: prdata <= {12'h000, sb_out_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			enable_r <= `OE_ENABLE_RESET;
		end else if (access && pwrite && paddr == `OE_ADDR_ENABLE) begin
			enable_r <= pwdata[N-1:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mask_r <= `OE_MASK_RESET;
		end else if (access && pwrite && paddr == `OE_ADDR_MASK) begin
			mask_r <= pwdata[N-1:0];
		end
	end

	// Requested enable per output
	logic [N-1:0] want, pin_held;
	// Pins placed at outputs five to twelve
	assign pin_held = {{(N - P - `OE_PIN_FIRST){1'b0}}, pin_s2_r,
		{`OE_PIN_FIRST{1'b0}}};
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (sideband_select) begin
				want[i] = sb_out_r[i] | mask_r[i];
			end else begin
				want[i] = enable_r[i] & ~pin_held[i];
			end
			if (power_down) begin
				want[i] = 1'b0;
			end
		end
	end

	// Per-output glitch-free gate, one slice each
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gate_slice
			gate_state_e st_r, st_nxt;
			drain_count_t cnt_r, cnt_nxt;

			always_comb begin
				st_nxt = st_r;
				cnt_nxt = cnt_r;
				case (st_r)
					GATE_OFF: begin
						// Start only while reference is low
						if (want[g] && ref_low) begin
							st_nxt = GATE_ON;
						end
					end
					GATE_ON: begin
						if (!want[g]) begin
							st_nxt = GATE_DRAIN;
							cnt_nxt = power_down ?
								`OE_MIN_VALID_CLOCKS : 3'h0;
						end
					end
					GATE_DRAIN: begin
						if (want[g]) begin
							st_nxt = GATE_ON;
						end else if (cnt_r >= `OE_MIN_VALID_CLOCKS) begin
							if (ref_low) begin
								st_nxt = GATE_OFF;
							end
						end else if (ref_rise) begin
							cnt_nxt = cnt_r + 3'h1;
						end
					end
					default: st_nxt = GATE_OFF;
				endcase
			end

			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					st_r <= GATE_OFF;
					cnt_r <= 3'h0;
				end else begin
					st_r <= st_nxt;
					cnt_r <= cnt_nxt;
				end
			end

			assign active[g] = (st_r != GATE_OFF);

			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					differential_output_p[g] <= 1'b0;
					differential_output_n[g] <= 1'b0;
				end else begin
					// Both legs low while gated off
					differential_output_p[g] <=
						(st_nxt != GATE_OFF) & ref_s2_r;
					differential_output_n[g] <=
						(st_nxt != GATE_OFF) & ~ref_s2_r;
				end
			end
		end
	endgenerate

endmodule // fanout_output_enable_control

/* core/fanout_oe_cfg.svh */
`ifndef FANOUT_OE_CFG_SVH
`define FANOUT_OE_CFG_SVH

// Output count and pin mapping
`define OE_NUM_OUTPUTS 20
`define OE_PIN_FIRST 5
`define OE_PIN_COUNT 8
`define OE_PIN_DATA 0
`define OE_PIN_SHIFT 1
`define OE_PIN_STROBE 5

// APB byte offsets
`define OE_ADDR_ENABLE 8'h00
`define OE_ADDR_MASK 8'h04
`define OE_ADDR_STATUS 8'h08
`define OE_ADDR_ACTIVE 8'h0C
`define OE_ADDR_SB_OUT 8'h10

// Reset values
`define OE_ENABLE_RESET 20'hF_FFFF
`define OE_MASK_RESET 20'h0_0000
`define OE_SB_RESET 20'hF_FFFF
`define OE_SHIFT_RESET 20'h0_0000

// Status field positions
`define OE_ST_SELECT 0
`define OE_ST_POWER_GOOD 1
`define OE_ST_STRAP_LO 2
`define OE_ST_STRAP_HI 4
`define OE_ST_BUS_ADDR 8

// Reference periods around enable changes
`define OE_MIN_VALID_CLOCKS 3'h4
`define OE_MAX_LATENCY 10

// Bus address per strap pair, high strap first
`define OE_SMB_ADDR_LL 8'hD8
`define OE_SMB_ADDR_LM 8'hDA
`define OE_SMB_ADDR_LH 8'hDE
`define OE_SMB_ADDR_ML 8'hC2
`define OE_SMB_ADDR_MM 8'hC4
`define OE_SMB_ADDR_MH 8'hC6
`define OE_SMB_ADDR_HL 8'hCA
`define OE_SMB_ADDR_HM 8'hCC
`define OE_SMB_ADDR_HH 8'hCE

`endif

/* core/fanout_oe_pkg.sv */
package fanout_oe_pkg;

	// Three-level strap reading
	typedef enum logic [1:0] {
		TRI_LOW = 2'h0,
		TRI_MID = 2'h1,
		TRI_HIGH = 2'h2
	} tri_level_e;

	// Per-output gate, Gray along off, on, drain
	typedef enum logic [1:0] {
		GATE_OFF = 2'h0,
		GATE_ON = 2'h1,
		GATE_DRAIN = 2'h3
	} gate_state_e;

	typedef logic [2:0] drain_count_t;

endpackage

/* dv/fanout_oe_monitor.sv */
module fanout_oe_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and outputs
	input wire logic reference_input,
	input wire logic power_good_powerdown,
	input wire logic [19:0] differential_output_p,
	input wire logic [19:0] differential_output_n
);
	logic [5:0] down_r;
	logic [5:0] ref_r;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Cycles spent in power-down
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			down_r <= 6'h00;
		else if (power_good_powerdown)
			down_r <= 6'h00;
		else if (down_r != 6'h3F)
			down_r <= down_r + 6'h01;
	end

	// Recent reference levels
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			ref_r <= 6'h00;
		else
			ref_r <= {ref_r[4:0], reference_input};
	end

	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_err;
		pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_errok;
		pslverr |-> pready;
	endproperty
	a_errok: assert property (p_errok) else $error("stray error");
	property p_upper;
		pready |-> prdata[31:20] == 12'h000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	property p_legs;
		(differential_output_p & differential_output_n) == 20'h0_0000;
	endproperty
	a_legs: assert property (p_legs) else $error("both legs high");
	property p_down;
		down_r > 6'h14 |-> differential_output_p == 20'h0_0000
			&& differential_output_n == 20'h0_0000;
	endproperty
	a_down: assert property (p_down) else $error("power-down");
	property p_rise;
		|(differential_output_p & ~$past(differential_output_p))
			|-> ref_r[2] && !ref_r[3];
	endproperty
	a_rise: assert property (p_rise) else $error("rise glitch");
	property p_fall;
		|(~differential_output_p & $past(differential_output_p))
			|-> !ref_r[2] && ref_r[3];
	endproperty
	a_fall: assert property (p_fall) else $error("fall glitch");
endmodule // fanout_oe_monitor

bind fanout_output_enable_control fanout_oe_monitor fanout_oe_monitor_i (.*);

/* dv/fanout_oe_board.sv */
module fanout_oe_board (
	// Clock
	input wire logic clock,
	// Enable pins
	output logic [7:0] output_enable_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial output_enable_n = 8'h00;

	// Each level held well above the pin sampling time
	task automatic hold(input logic [7:0] v);
		output_enable_n <= v;
		repeat (4) @(posedge clock);
	endtask

	// First bit lands in output 0
	task automatic send(input logic [19:0] v);
		for (int i = 0; i < 20; i++) begin
			hold({2'h0, 1'h1, 3'h0, 1'h0, v[i]});
			hold({2'h0, 1'h1, 3'h0, 1'h1, v[i]});
		end
		hold(8'h20);
		hold(8'h00);
	endtask
endmodule // fanout_oe_board

/* dv/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fanout_oe_pkg::*;

	logic clock, rst, psel, penable, pwrite, pready, pslverr, ev;
	logic reference_input, sideband_select_strap, power_good_powerdown;
	logic [7:0] paddr, output_enable_n;
	logic [31:0] pwdata, prdata, rv;
	logic [19:0] differential_output_p, differential_output_n;
	tri_level_e address_strap_low, address_strap_high;
	int error_cnt = 0;
	int checked = 0;
	int seed = 57;
	int rc = 0;

	fanout_output_enable_control fanout_output_enable_control_i (.*);
	fanout_oe_board fanout_oe_board_i (.*);

	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	// Reference at a tenth of the clock rate
	always @(posedge clock) begin
		rc <= (rc + 1) % 10;
		reference_input <= rc < 5;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("errors=%0d checks=%0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock);
		while (pready !== 1'h1 && ++i < 20);
		if (i == 20) begin
			error_cnt++;
			print_verdict;
		end else begin
			rv = prdata;
			ev = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge clock);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0000_0000);
		cmp(rv, exp);
	endtask

	// Settle for twelve reference periods, then gate state and toggles
	task automatic look(input logic [19:0] exp);
		logic [19:0] m, mn;
		m = 20'h0_0000;
		mn = 20'h0_0000;
		repeat (120) @(posedge clock);
		rd(8'h0C, {12'h000, exp});
		repeat (12) @(posedge clock) begin
			m |= differential_output_p;
			mn |= differential_output_n;
		end
		cmp({12'h000, m}, {12'h000, exp});
		cmp({12'h000, mn}, {12'h000, exp});
	endtask

	initial begin
		logic [19:0] en, pin, mk, sb;
		rst = 1'h1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		reference_input = 1'h0;
		sideband_select_strap = 1'h0;
		power_good_powerdown = 1'h1;
		address_strap_low = TRI_MID;
		address_strap_high = TRI_HIGH;
		repeat (12) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		rd(8'h00, 32'h000F_FFFF);
		rd(8'h04, 32'h0000_0000);
		rd(8'h10, 32'h000F_FFFF);
		rd(8'h08, 32'h0000_CC26);
		apb(1'h1, 8'h14, 32'hFFFF_FFFF);
		cmp({31'h0, ev}, 32'h0000_0001);
		look(20'hF_FFFF);
		for (int k = 0; k < 4; k++) begin
			en = 20'($random(seed));
			pin = 20'($random(seed));
			apb(1'h1, 8'h00, {12'h000, en});
			fanout_oe_board_i.hold(pin[7:0]);
			look(en & ~{7'h00, pin[7:0], 5'h00});
		end
		fanout_oe_board_i.hold(8'h00);
		sideband_select_strap <= 1'h1;
		for (int k = 0; k < 3; k++) begin
			sb = 20'($random(seed));
			mk = 20'($random(seed) & $random(seed));
			apb(1'h1, 8'h04, {12'h000, mk});
			apb(1'h1, 8'h00, 32'($random(seed)));
			fanout_oe_board_i.send(sb);
			rd(8'h10, {12'h000, sb});
			look(sb | mk);
		end
		rd(8'h08, 32'h0000_CC27);
		power_good_powerdown <= 1'h0;
		look(20'h0_0000);
		rd(8'h08, 32'h0000_CC25);
		power_good_powerdown <= 1'h1;
		look(sb | mk);
		print_verdict;
	end
endmodule // tb
